/* File: stp_top.sv */
`timescale 1ns/1ps
`include "stp_cfg.svh"
// Summary of operation
// - id bit 0 always reads one to show an id register exists.
// - id bits 11:1 hold the fixed manufacturer code.
// - id bits 28:12 hold part code per width, 31:29 the revision.
// - code 001 loads id register between data in and out.
// - code 010 captures ring, selects chain, forces memory outputs high impedance.
// - code 100 captures ring and selects chain, memory unaffected.
// - code 111 places the one-bit bypass register in the path.
// - code 000 is external test, capturing the boundary ring.
// - the pll references the positive main input clock.
module stp_top #(
	parameter int BSR_LEN = `STP_BSR_LEN,
	parameter int LOCK_CYCLES = `STP_LOCK_CYCLES,
	parameter logic [10:0] MFR_CODE = 11'h5A5, // arbitrary value
	parameter logic [16:0] PART_CODE = 17'h01234, // arbitrary value
	parameter logic [2:0] REV_CODE = 3'h1 // arbitrary value
) (
	// system
	input wire logic ref_clk,
	input wire logic rst_b,
	// pll
	input wire logic pll_enable_pin,
	output logic pll_locked,
	// memory output drivers
	output logic mem_out_hiz,
	// test link
	input wire logic tck,
	input wire logic trst_b,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int PAD = `STP_BSR_WORDS * 32;
	// fixed identification word, bit 0 tied to one
	localparam logic [31:0] ID_VALUE = {REV_CODE, PART_CODE, MFR_CODE, 1'b1};

	stp_ring_if #(.BSR_LEN(BSR_LEN)) ring ();

	logic [PAD-1:0] pin_state;
	logic [PAD-1:0] cap_pad;
	logic [31:0] ctrl;
	logic [31:0] lock_cnt;
	logic pll_en_s1;
	logic pll_en_s2;
	logic hiz_s1;
	logic hiz_s2;
	logic tog_s1;
	logic tog_s2;
	logic tog_s3;
	logic cap_count_en;
	logic [15:0] cap_count;
	logic [2:0] instr_s1;
	logic [2:0] instr_s2;
	logic [2:0] instr_seen;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] next_rdata;
	logic next_rerr;
	logic w_err;

	stp_tap #(.BSR_LEN(BSR_LEN), .ID_VALUE(ID_VALUE)) u_tap (
		.tck(tck),
		.trst_b(trst_b),
		.tms(tms),
		.tdi(tdi),
		.tdo(tdo),
		.tdo_oe(tdo_oe),
		.ring(ring.tap)
	);

	// last cell is internal, it echoes the pll lock state rather than a ball
	assign ring.pins = {pll_locked, pin_state[BSR_LEN-2:0]};
	assign cap_pad = {{(PAD-BSR_LEN){1'b0}}, ring.captured};

	// crossings from the link domain
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hiz_s1 <= 1'b0;
			hiz_s2 <= 1'b0;
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			instr_s1 <= 3'h0;
			instr_s2 <= 3'h0;
		end else begin
			hiz_s1 <= ring.outputs_hiz;
			hiz_s2 <= hiz_s1;
			tog_s1 <= ring.cap_toggle[0];
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			instr_s1 <= ring.instr;
			instr_s2 <= instr_s1;
		end
	end

	// the code is a multi-bit word: only take it once both stages agree, so a skewed change never shows
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			instr_seen <= 3'h0;
		end else if (instr_s1 == instr_s2) begin
			instr_seen <= instr_s2;
		end
	end

	assign cap_count_en = tog_s2 ^ tog_s3;
	assign mem_out_hiz = hiz_s2;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cap_count <= 16'h0000;
		end else if (cap_count_en) begin
			cap_count <= cap_count + 16'h0001;
		end
	end

	// lock timer restarts whenever the enable pin drops or the pll is disabled
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pll_en_s1 <= 1'b0;
			pll_en_s2 <= 1'b0;
		end else begin
			pll_en_s1 <= pll_enable_pin;
			pll_en_s2 <= pll_en_s1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_cnt <= 32'h00000000;
			pll_locked <= 1'b0;
		end else if (!pll_en_s2 || ctrl[0]) begin
			lock_cnt <= 32'h00000000;
			pll_locked <= 1'b0;
		end else if (lock_cnt >= 32'(LOCK_CYCLES - 1)) begin
			pll_locked <= 1'b1;
		end else begin
			lock_cnt <= lock_cnt + 32'h00000001;
		end
	end

	// axi4-lite write path, address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
		end
	end

	assign w_err = !((aw_addr == `STP_REG_CTRL) || ((aw_addr >= `STP_REG_BSR_IN0)
		&& (aw_addr < 8'(`STP_REG_BSR_IN0 + 4 * `STP_BSR_WORDS))));

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= `STP_CTRL_RESET;
			pin_state <= '0;
		end else if (aw_held && w_held && !w_err) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb[b]) begin
					if (aw_addr == `STP_REG_CTRL) begin
						ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
					end else begin
						pin_state[(int'(aw_addr[3:2]) * 32) + b*8 +: 8] <= w_data[b*8 +: 8];
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (aw_held && w_held) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= w_err ? 2'b10 : 2'b00;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read path; captured ring words may tear if read while a capture lands
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		next_rdata = 32'h00000000;
		next_rerr = 1'b0;
		if (s_axi_araddr == `STP_REG_CTRL) begin
			next_rdata = ctrl;
		end else if (s_axi_araddr == `STP_REG_STATUS) begin
			next_rdata = {cap_count, 8'h00, instr_seen, 2'b00, hiz_s2, pll_en_s2, pll_locked};
		end else if (s_axi_araddr == `STP_REG_IDCODE) begin
			next_rdata = ID_VALUE;
		end else if ((s_axi_araddr >= `STP_REG_BSR_IN0)
			&& (s_axi_araddr < 8'(`STP_REG_BSR_IN0 + 4 * `STP_BSR_WORDS))) begin
			next_rdata = pin_state[int'(s_axi_araddr[3:2]) * 32 +: 32];
		end else if ((s_axi_araddr >= `STP_REG_BSR_CAP0)
			&& (s_axi_araddr < 8'(`STP_REG_BSR_CAP0 + 4 * `STP_BSR_WORDS))) begin
			next_rdata = cap_pad[int'(s_axi_araddr[3:2]) * 32 +: 32];
		end else begin
			next_rerr = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rerr ? 2'b10 : 2'b00;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : stp_top

/* File: stp_cfg.svh */
`ifndef STP_CFG_SVH
`define STP_CFG_SVH

// instruction codes
`define STP_IR_EXTEST 3'h0
`define STP_IR_IDCODE 3'h1
`define STP_IR_SAMPLEZ 3'h2
`define STP_IR_SAMPLE 3'h4
`define STP_IR_BYPASS 3'h7
`define STP_IR_WIDTH 3
`define STP_BSR_LEN 109
// identification register fields
`define STP_ID_PRESENT_BIT 0
`define STP_ID_MFR_LSB 1
`define STP_ID_PART_LSB 12
`define STP_ID_REV_LSB 29
// pll lock timing
`define STP_LOCK_TIME_US 20
`define STP_CLK_MHZ 100
`define STP_LOCK_CYCLES (`STP_LOCK_TIME_US * `STP_CLK_MHZ)
// axi4-lite register map
`define STP_REG_CTRL 8'h00
`define STP_REG_STATUS 8'h04
`define STP_REG_IDCODE 8'h08
`define STP_REG_BSR_IN0 8'h10
`define STP_REG_BSR_CAP0 8'h30
`define STP_BSR_WORDS 4
`define STP_CTRL_RESET 32'h00000000

`endif

/* File: stp_pkg.sv */
package stp_pkg;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
		TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
		TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} stp_tap_state_e;
	typedef logic [2:0] stp_instr_t;
endpackage : stp_pkg

/* File: stp_ring_if.sv */
`timescale 1ns/1ps
// boundary ring exchange between the tap and the register side
interface stp_ring_if #(parameter int BSR_LEN = 109);
	logic [BSR_LEN-1:0] pins;
	logic [BSR_LEN-1:0] captured;
	logic [3:0] cap_toggle;
	logic [2:0] instr;
	logic outputs_hiz;
	modport tap (input pins, output captured, output cap_toggle, output instr, output outputs_hiz);
	modport host (output pins, input captured, input cap_toggle, input instr, input outputs_hiz);
endinterface : stp_ring_if

/* File: stp_tap.sv */
`timescale 1ns/1ps
`include "stp_cfg.svh"
// test access port state machine on the link clock
module stp_tap #(
	parameter int BSR_LEN = `STP_BSR_LEN,
	parameter logic [31:0] ID_VALUE = 32'h00000001
) (
	// link
	input wire logic tck,
	input wire logic trst_b,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// ring
	stp_ring_if.tap ring
);
	stp_pkg::stp_tap_state_e state;
	stp_pkg::stp_tap_state_e next_state;
	stp_pkg::stp_instr_t ir_shift;
	stp_pkg::stp_instr_t ir;
	logic [31:0] id_shift;
	logic byp;
	logic [BSR_LEN-1:0] bsr;
	logic [BSR_LEN-1:0] pins_s1;
	logic [BSR_LEN-1:0] pins_s2;
	logic cap_tog;
	logic sel_bsr;
	logic dr_out;

	assign sel_bsr = (ir == `STP_IR_EXTEST) || (ir == `STP_IR_SAMPLEZ) || (ir == `STP_IR_SAMPLE);
	assign ring.instr = ir;
	assign ring.captured = bsr;
	assign ring.cap_toggle = {cap_tog, cap_tog, cap_tog, cap_tog};
	assign ring.outputs_hiz = (ir == `STP_IR_SAMPLEZ);

	always_comb begin
		next_state = state;
		unique case (state)
			stp_pkg::TAP_RESET: next_state = tms ? stp_pkg::TAP_RESET : stp_pkg::TAP_IDLE;
			stp_pkg::TAP_IDLE: next_state = tms ? stp_pkg::TAP_SEL_DR : stp_pkg::TAP_IDLE;
			stp_pkg::TAP_SEL_DR: next_state = tms ? stp_pkg::TAP_SEL_IR : stp_pkg::TAP_CAP_DR;
			stp_pkg::TAP_CAP_DR: next_state = tms ? stp_pkg::TAP_EXIT1_DR : stp_pkg::TAP_SHIFT_DR;
			stp_pkg::TAP_SHIFT_DR: next_state = tms ? stp_pkg::TAP_EXIT1_DR : stp_pkg::TAP_SHIFT_DR;
			stp_pkg::TAP_EXIT1_DR: next_state = tms ? stp_pkg::TAP_UPD_DR : stp_pkg::TAP_PAUSE_DR;
			stp_pkg::TAP_PAUSE_DR: next_state = tms ? stp_pkg::TAP_EXIT2_DR : stp_pkg::TAP_PAUSE_DR;
			stp_pkg::TAP_EXIT2_DR: next_state = tms ? stp_pkg::TAP_UPD_DR : stp_pkg::TAP_SHIFT_DR;
			stp_pkg::TAP_UPD_DR: next_state = tms ? stp_pkg::TAP_SEL_DR : stp_pkg::TAP_IDLE;
			stp_pkg::TAP_SEL_IR: next_state = tms ? stp_pkg::TAP_RESET : stp_pkg::TAP_CAP_IR;
			stp_pkg::TAP_CAP_IR: next_state = tms ? stp_pkg::TAP_EXIT1_IR : stp_pkg::TAP_SHIFT_IR;
			stp_pkg::TAP_SHIFT_IR: next_state = tms ? stp_pkg::TAP_EXIT1_IR : stp_pkg::TAP_SHIFT_IR;
			stp_pkg::TAP_EXIT1_IR: next_state = tms ? stp_pkg::TAP_UPD_IR : stp_pkg::TAP_PAUSE_IR;
			stp_pkg::TAP_PAUSE_IR: next_state = tms ? stp_pkg::TAP_EXIT2_IR : stp_pkg::TAP_PAUSE_IR;
			stp_pkg::TAP_EXIT2_IR: next_state = tms ? stp_pkg::TAP_UPD_IR : stp_pkg::TAP_SHIFT_IR;
			stp_pkg::TAP_UPD_IR: next_state = tms ? stp_pkg::TAP_SEL_DR : stp_pkg::TAP_IDLE;
		endcase
	end

	always_ff @(posedge tck or negedge trst_b) begin
		if (!trst_b) begin
			state <= stp_pkg::TAP_RESET;
		end else begin
			state <= next_state;
		end
	end

	// the ring pins come from the system clock domain
	always_ff @(posedge tck or negedge trst_b) begin
		if (!trst_b) begin
			pins_s1 <= '0;
			pins_s2 <= '0;
		end else begin
			pins_s1 <= ring.pins;
			pins_s2 <= pins_s1;
		end
	end

	always_ff @(posedge tck or negedge trst_b) begin
		if (!trst_b) begin
			ir_shift <= `STP_IR_IDCODE;
			ir <= `STP_IR_IDCODE;
		end else if (state == stp_pkg::TAP_RESET) begin
			ir <= `STP_IR_IDCODE;
		end else if (state == stp_pkg::TAP_CAP_IR) begin
			ir_shift <= 3'h1;
		end else if (state == stp_pkg::TAP_SHIFT_IR) begin
			ir_shift <= {tdi, ir_shift[2:1]};
		end else if (state == stp_pkg::TAP_UPD_IR) begin
			ir <= ir_shift;
		end
	end

	always_ff @(posedge tck or negedge trst_b) begin
		if (!trst_b) begin
			id_shift <= '0;
			byp <= 1'b0;
			bsr <= '0;
			cap_tog <= 1'b0;
		end else if (state == stp_pkg::TAP_CAP_DR) begin
			id_shift <= ID_VALUE;
			byp <= 1'b0;
			if (sel_bsr) begin
				bsr <= pins_s2;
				cap_tog <= ~cap_tog;
			end
		end else if (state == stp_pkg::TAP_SHIFT_DR) begin
			id_shift <= {tdi, id_shift[31:1]};
			byp <= tdi;
			if (sel_bsr) begin
				bsr <= {tdi, bsr[BSR_LEN-1:1]};
			end
		end
	end

	always_comb begin
		if (state == stp_pkg::TAP_SHIFT_IR) begin
			dr_out = ir_shift[0];
		end else if (sel_bsr) begin
			dr_out = bsr[0];
		end else if (ir == `STP_IR_IDCODE) begin
			dr_out = id_shift[0];
		end else begin
			// reserved codes fall back to bypass
			dr_out = byp;
		end
	end

	// tdo changes on the falling edge of tck
	always_ff @(negedge tck or negedge trst_b) begin
		if (!trst_b) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo <= dr_out;
			tdo_oe <= (state == stp_pkg::TAP_SHIFT_DR) || (state == stp_pkg::TAP_SHIFT_IR);
		end
	end
endmodule : stp_tap

/* File: stp_scan_ctrl.sv */
`timescale 1ns/1ps
// external scan controller; tck runs only inside frames, at a 6 ns period
module stp_scan_ctrl (
	// link
	output logic tck,
	output logic trst_b,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial begin
		tck = 1'b0;
		trst_b = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// tdo changed on the fall, so it is taken just before the rise
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#3 o = tdo;
		tck = 1'b1;
		#3 tck = 1'b0;
	endtask : step
	task automatic walk(input logic [3:0] m, input int n);
		logic o;
		#1.7;
		for (int i = 0; i < n; i++) step(m[i], 1'b0, o);
	endtask : walk
	task automatic shift(input int n, input logic [139:0] din, output logic [139:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
		walk(4'h1, 2);
		// a released data line must not keep looking valid
		tdi = ~tdi;
	endtask : shift
	task automatic load_ir(input logic [2:0] c, output logic [2:0] cap);
		logic [139:0] o;
		walk(4'h3, 4);
		shift(3, {137'h0, c}, o);
		cap = o[2:0];
	endtask : load_ir
	task automatic scan_dr(input int n, input logic [139:0] din, output logic [139:0] dout);
		walk(4'h1, 3);
		shift(n, din, dout);
	endtask : scan_dr
	task automatic reset_tap;
		trst_b = 1'b0;
		#20 trst_b = 1'b1;
		walk(4'hF, 4);
		walk(4'h1, 2);
	endtask : reset_tap
endmodule : stp_scan_ctrl

/* File: stp_top_props.sv */
`timescale 1ns/1ps
module stp_top_props #(
	parameter int LOCK_CYCLES = 2000,
	parameter logic [10:0] MFR_CODE = 11'h000,
	parameter logic [16:0] PART_CODE = 17'h00000,
	parameter logic [2:0] REV_CODE = 3'h0
) (
	// system
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic pll_enable_pin,
	input wire logic pll_locked,
	// link
	input wire logic tck,
	input wire logic trst_b,
	input wire logic tms,
	input wire logic tdo_oe,
	// bus
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	logic [31:0] en_cnt;
	logic ar_go;
	assign ar_go = s_axi_arvalid && s_axi_arready;
	// raw enable age; the design sees the pin two flops later, so this never lags
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) en_cnt <= '0;
		else if (!pll_enable_pin) en_cnt <= '0;
		else if (en_cnt != 32'hFFFFFFFF) en_cnt <= en_cnt + 32'h1;
	end
	a_id_present: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ar_go && s_axi_araddr == 8'h08 |=> s_axi_rvalid && s_axi_rdata[0]) else $error("id presence bit low");
	a_id_maker: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ar_go && s_axi_araddr == 8'h08 |=> s_axi_rdata[11:1] == MFR_CODE) else $error("id maker field wrong");
	a_id_part_rev: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ar_go && s_axi_araddr == 8'h08 |=> s_axi_rdata[31:12] == {REV_CODE, PART_CODE}) else $error("id part wrong");
	a_lock_wait: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(pll_locked) |-> en_cnt >= 32'(LOCK_CYCLES)) else $error("lock came early");
	a_tap_leave: assert property (@(posedge tck) disable iff (!trst_b)
		tms |=> !tdo_oe) else $error("tdo driven outside shift");
	a_rd_answer: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ar_go |=> s_axi_rvalid) else $error("read answer late");
	a_rd_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_wr_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped");
	a_rd_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ar_go && s_axi_araddr == 8'hFC |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read");
	c_id_read: cover property (@(posedge ref_clk) ar_go && s_axi_araddr == 8'h08);
	c_locked: cover property (@(posedge ref_clk) $rose(pll_locked));
	c_shift: cover property (@(posedge tck) tdo_oe);
endmodule : stp_top_props

bind stp_top stp_top_props #(.LOCK_CYCLES(LOCK_CYCLES), .MFR_CODE(MFR_CODE), .PART_CODE(PART_CODE),
	.REV_CODE(REV_CODE)) u_props (.*);

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "stp_cfg.svh"
module tb_top;
	typedef struct {logic [2:0] code; int len; logic hiz;} stp_case_s;
	localparam int LOCK = 20;
	localparam logic [10:0] MFR = 11'h2B3; // arbitrary value
	localparam logic [16:0] PART = 17'h0ABCD; // arbitrary value
	localparam logic [2:0] REV = 3'h5; // arbitrary value
	localparam logic [31:0] ID = {REV, PART, MFR, 1'b1};
	localparam logic [31:0] PINS = 32'hA5C30F96;
	logic ref_clk = 1'b0;
	logic rst_b, pll_enable_pin, pll_locked, mem_out_hiz, tck, trst_b, tms, tdi, tdo, tdo_oe;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [139:0] o;
	logic [2:0] cap;
	int err_count = 0;
	int checks_done = 0;
	int hi;
	int ncap = 0;
	stp_case_s rows[5] = '{'{3'h0, 109, 1'b0}, '{3'h1, 32, 1'b0}, '{3'h2, 109, 1'b1}, '{3'h4, 109, 1'b0},
		'{3'h7, 1, 1'b0}};
	always #5 ref_clk = ~ref_clk;
	stp_top #(.LOCK_CYCLES(LOCK), .MFR_CODE(MFR), .PART_CODE(PART), .REV_CODE(REV)) u_dut (.*);
	stp_scan_ctrl u_scan (.tck(tck), .trst_b(trst_b), .tms(tms), .tdi(tdi), .tdo(tdo));
	task automatic chk(input logic [139:0] seen, input logic [139:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				{r, d} = {s_axi_rresp, s_axi_rdata};
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : axi_rd
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	initial begin
		#100us;
		err_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		report_and_stop();
	end
	initial begin
		{rst_b, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		pll_enable_pin = 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		axi_rd(`STP_REG_CTRL);
		chk(d, `STP_CTRL_RESET);
		axi_wr(`STP_REG_IDCODE, 32'h0);
		axi_rd(`STP_REG_IDCODE);
		chk(d, ID);
		axi_wr(8'hFC, 32'h1);
		chk(r, 2'b10);
		axi_rd(8'hFC);
		chk({r, d}, {2'b10, 32'h0});
		$display("test registers done");
		@(posedge ref_clk);
		pll_enable_pin <= 1'b1;
		repeat (LOCK / 2) @(posedge ref_clk);
		chk(pll_locked, 1'b0);
		repeat (LOCK) @(posedge ref_clk);
		chk(pll_locked, 1'b1);
		axi_wr(`STP_REG_CTRL, 32'h1);
		repeat (4) @(posedge ref_clk);
		chk(pll_locked, 1'b0);
		axi_wr(`STP_REG_CTRL, 32'h0);
		repeat (LOCK + 6) @(posedge ref_clk);
		chk(pll_locked, 1'b1);
		$display("test pll done");
		axi_wr(`STP_REG_BSR_IN0, PINS);
		u_scan.reset_tap();
		u_scan.scan_dr(32, 140'h0, o);
		chk(o[31:0], ID);
		foreach (rows[k]) begin
			u_scan.load_ir(rows[k].code, cap);
			chk(cap, 3'b001);
			u_scan.scan_dr(140, 140'h1, o);
			hi = -1;
			for (int i = 0; i < 140; i++) if (o[i] === 1'b1) hi = i;
			chk(hi, rows[k].len);
			chk(tdo_oe, 1'b0);
			if (rows[k].len == 109) ncap++;
			if (rows[k].len == 32) chk(o[31:0], ID);
			if (rows[k].len == 1) chk(o[0], 1'b0);
			if (rows[k].len == 109) chk({o[108], o[31:0]}, {1'b1, PINS});
			repeat (5) @(posedge ref_clk);
			chk(mem_out_hiz, rows[k].hiz);
			axi_rd(`STP_REG_STATUS);
			chk({d[7:5], d[2]}, {rows[k].code, rows[k].hiz});
			chk(d[31:16], 16'(ncap));
			$display("test code %0h done", rows[k].code);
		end
		u_scan.load_ir(3'h2, cap);
		u_scan.reset_tap();
		repeat (5) @(posedge ref_clk);
		chk(mem_out_hiz, 1'b0);
		$display("test tap reset done");
		report_and_stop();
	end
endmodule : tb_top
